// *** hw/cmi_pkg.sv ***
// Purpose: Shared types and constants for the CAN acceptance mask and interrupt flag block
// Assumes: 16-bit register port with word addresses; one core clock
// Notes: Mask and frame words share one 32-bit layout so filtering is a bitwise operation
package cmi_pkg;
   typedef logic [3:0] cmi_addr_t;
   typedef logic [15:0] cmi_data_t;
   typedef logic [31:0] cmi_word_t;
   typedef logic [4:0] cmi_code_t;

   // Register offsets
   localparam cmi_addr_t GLOBAL_MASK_BASE_OFS = 4'h0;
   localparam cmi_addr_t GLOBAL_MASK_EXT_OFS = 4'h1;
   localparam cmi_addr_t BUF14_MASK_BASE_OFS = 4'h2;
   localparam cmi_addr_t BUF14_MASK_EXT_OFS = 4'h3;
   localparam cmi_addr_t IRQ_ENABLE_OFS = 4'h4;
   localparam cmi_addr_t IRQ_PENDING_OFS = 4'h5;
   localparam cmi_addr_t IRQ_CLEAR_OFS = 4'h6;
   localparam cmi_addr_t IRQ_CODE_ENABLE_OFS = 4'h7;
   localparam cmi_addr_t NODE_STATUS_AND_CODE_OFS = 4'h8;

   localparam cmi_data_t REG_RESET = 16'h0000;
   localparam cmi_data_t READ_ZERO = 16'h0000;

   // Interrupt register layout: bit 15 error, bits 14..0 buffers
   localparam int NUM_BUF = 15;
   localparam int ERR_BIT = 15;
   localparam logic [3:0] BASIC_BUF = 4'he;

   // Word layout: [31:21] id 28..18, [20] rtr/srr, [19] ide, [18:1] id 17..0, [0] ext rtr
   localparam cmi_word_t STD_USED_BITS = 32'hfff8_0000;
   localparam cmi_word_t EXT_USED_BITS = 32'hffff_ffff;

   localparam cmi_code_t CODE_NONE = 5'h00;
   localparam cmi_code_t CODE_ERR = 5'h10;
   localparam logic CODE_REQ = 1'b1;

   typedef struct packed {
      logic valid;
      logic ext;
      logic [3:0] buf_sel;
      cmi_word_t rx_word;
      cmi_word_t stored_word;
   } cmi_frame_t;

   typedef struct packed {
      logic hit;
      logic valid;
      cmi_word_t merged_word;
   } cmi_accept_t;

   typedef struct packed {
      cmi_data_t gmask_base;
      cmi_data_t gmask_ext;
      cmi_data_t bmask_base;
      cmi_data_t bmask_ext;
      cmi_data_t irq_enable;
      cmi_data_t irq_pending;
      cmi_data_t irq_code_enable;
      cmi_data_t rdata;
      cmi_accept_t acc;
      logic irq;
      cmi_code_t code;
   } cmi_state_t;
endpackage

// *** hw/cmi_regs.sv ***
// Purpose: Acceptance masking, interrupt enable, pending, clear and code logic
// Assumes: Protocol engine and CPU port run on SYS_CLK; events are one-cycle pulses
// Notes: Notes on behaviour list follows
// Notes on behaviour
// - Mask 0 compares bit; 1 copies incoming bit
// - Extended frames use every global mask bit
// - Standard frames use mask 28..18, RTR, IDE
// - Global mask split into base and extended halves
// - Basic mask replaces global mask for buffer 14
// - Basic mask 0 compares, 1 overwrites stored bit
// - Extended frames use every basic mask bit
// - Standard frames use basic 28..18, RTR, IDE
// - Error enable gates error interrupt
// - Enable bit n gates buffer n interrupt
// - Buffer transfer sets pending bit n
// - Error counter status change sets error pending
// - Clear write ones reset buffer pending bits
// - Clear bit 15 resets error pending
// - Code enable n admits buffer n to code
// - Code enable 15 admits error to code
// - Code shows highest pending enabled source
`timescale 1ns/100ps

module cmi_regs (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire cmi_pkg::cmi_addr_t ADDR,
   input wire cmi_pkg::cmi_data_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output cmi_pkg::cmi_data_t RDATA,
   input wire cmi_pkg::cmi_frame_t FRAME,
   output cmi_pkg::cmi_accept_t ACCEPT,
   input wire logic [14:0] BUF_EVT,
   input wire logic ERR_STAT_CHG,
   output logic IRQ,
   output cmi_pkg::cmi_code_t INT_CODE
);
   import cmi_pkg::*;

   cmi_state_t st_r;
   cmi_state_t st_nxt;

   // Bits a frame type actually uses; unused bits neither compare nor copy
   function automatic cmi_word_t used_bits(input logic ext);
      used_bits = ext ? EXT_USED_BITS : STD_USED_BITS;
   endfunction

   function automatic logic id_hit(input cmi_frame_t f, input cmi_word_t mask);
      cmi_word_t care;
      care = ~mask & used_bits(f.ext);
      id_hit = ((f.rx_word ^ f.stored_word) & care) == '0;
   endfunction

   function automatic cmi_word_t id_merge(input cmi_frame_t f, input cmi_word_t mask);
      cmi_word_t dc;
      dc = mask & used_bits(f.ext);
      id_merge = (f.rx_word & dc) | (f.stored_word & ~dc);
   endfunction

   // Error first, then buffer 0 upward; buffer n codes as CODE_REQ with n+1 in the low four bits
   function automatic cmi_code_t irq_code(input cmi_data_t req);
      irq_code = CODE_NONE;
      if (req[ERR_BIT]) begin
         irq_code = CODE_ERR;
      end else begin
         for (int n = NUM_BUF - 1; n >= 0; n--) begin
            if (req[n]) begin
               irq_code = {CODE_REQ, 4'(n + 1)};
            end
         end
      end
   endfunction

   cmi_word_t gmask_word;
   cmi_word_t bmask_word;
   cmi_word_t sel_mask;
   cmi_data_t set_vec;
   cmi_data_t clr_vec;

   // Two 16-bit halves form the 32-bit mask word
   assign gmask_word = {st_r.gmask_base, st_r.gmask_ext};
   assign bmask_word = {st_r.bmask_base, st_r.bmask_ext};
   assign sel_mask = (FRAME.buf_sel == BASIC_BUF) ? bmask_word : gmask_word;
   assign set_vec = {ERR_STAT_CHG, BUF_EVT};
   assign clr_vec = (WR && ADDR == IRQ_CLEAR_OFS) ? WDATA : READ_ZERO;

   always_comb begin
      st_nxt = st_r;
      if (WR) begin
         if (ADDR == GLOBAL_MASK_BASE_OFS) begin
            st_nxt.gmask_base = WDATA;
         end else if (ADDR == GLOBAL_MASK_EXT_OFS) begin
            st_nxt.gmask_ext = WDATA;
         end else if (ADDR == BUF14_MASK_BASE_OFS) begin
            st_nxt.bmask_base = WDATA;
         end else if (ADDR == BUF14_MASK_EXT_OFS) begin
            st_nxt.bmask_ext = WDATA;
         end else if (ADDR == IRQ_ENABLE_OFS) begin
            st_nxt.irq_enable = WDATA;
         end else if (ADDR == IRQ_CODE_ENABLE_OFS) begin
            st_nxt.irq_code_enable = WDATA;
         end
      end
      // Error pending stays until software clears it
      st_nxt.irq_pending = (st_r.irq_pending & ~clr_vec) | set_vec;
      // Request and code follow the pending word the same cycle it updates
      st_nxt.irq = |(st_nxt.irq_pending & st_nxt.irq_enable);
      st_nxt.code = irq_code(st_nxt.irq_pending & st_nxt.irq_code_enable);
      st_nxt.acc.valid = FRAME.valid;
      st_nxt.acc.hit = FRAME.valid && id_hit(FRAME, sel_mask);
      st_nxt.acc.merged_word = id_merge(FRAME, sel_mask);
      st_nxt.rdata = READ_ZERO;
      if (RD) begin
         if (ADDR == GLOBAL_MASK_BASE_OFS) begin
            st_nxt.rdata = st_r.gmask_base;
         end else if (ADDR == GLOBAL_MASK_EXT_OFS) begin
            st_nxt.rdata = st_r.gmask_ext;
         end else if (ADDR == BUF14_MASK_BASE_OFS) begin
            st_nxt.rdata = st_r.bmask_base;
         end else if (ADDR == BUF14_MASK_EXT_OFS) begin
            st_nxt.rdata = st_r.bmask_ext;
         end else if (ADDR == IRQ_ENABLE_OFS) begin
            st_nxt.rdata = st_r.irq_enable;
         end else if (ADDR == IRQ_PENDING_OFS) begin
            st_nxt.rdata = st_r.irq_pending;
         end else if (ADDR == IRQ_CODE_ENABLE_OFS) begin
            st_nxt.rdata = st_r.irq_code_enable;
         end else if (ADDR == NODE_STATUS_AND_CODE_OFS) begin
            st_nxt.rdata = {11'h000, st_r.code};
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RDATA = st_r.rdata;
   assign ACCEPT = st_r.acc;
   assign IRQ = st_r.irq;
   assign INT_CODE = st_r.code;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   a_buf_set_seen: assert property (BUF_EVT != '0 |=>
      ((st_r.irq_pending[14:0] & $past(BUF_EVT)) == $past(BUF_EVT)))
      else $error("buffer event did not set pending");
   a_err_set_seen: assert property (ERR_STAT_CHG |=> st_r.irq_pending[ERR_BIT])
      else $error("error status change did not set pending");
   a_set_beats_clear: assert property ((WR && ADDR == IRQ_CLEAR_OFS && BUF_EVT[0]
      && WDATA[0]) |=> st_r.irq_pending[0])
      else $error("clear beat a simultaneous set");
   a_clear_ones: assert property ((WR && ADDR == IRQ_CLEAR_OFS && set_vec == '0)
      |=> (st_r.irq_pending & $past(WDATA)) == '0)
      else $error("clear write left a pending bit");
   a_clear_err: assert property ((WR && ADDR == IRQ_CLEAR_OFS && WDATA[ERR_BIT]
      && !ERR_STAT_CHG) |=> !st_r.irq_pending[ERR_BIT])
      else $error("error pending not cleared");
   a_clear_zero_keeps: assert property ((WR && ADDR == IRQ_CLEAR_OFS && WDATA == '0)
      |=> st_r.irq_pending == ($past(st_r.irq_pending) | $past(set_vec)))
      else $error("zero clear bits changed pending");
   a_err_irq_rises: assert property ((ERR_STAT_CHG && st_r.irq_enable[ERR_BIT]
      && !(WR && ADDR == IRQ_ENABLE_OFS)) |=> IRQ)
      else $error("enabled error did not raise request");
   a_irq_needs_enable: assert property (st_r.irq_enable == '0 |-> !IRQ)
      else $error("request without any enable");
   a_code_none: assert property ((st_r.irq_pending & st_r.irq_code_enable) == '0
      |-> INT_CODE == CODE_NONE)
      else $error("code shown with nothing enabled");
   a_code_error: assert property ((st_r.irq_pending[ERR_BIT]
      && st_r.irq_code_enable[ERR_BIT]) |-> INT_CODE == CODE_ERR)
      else $error("error not top in code");
   a_code_buf14: assert property (((st_r.irq_pending & st_r.irq_code_enable)
      == 16'h4000) |-> INT_CODE == 5'h1f)
      else $error("buffer 14 code wrong");
   a_std_ignores_low: assert property ((FRAME.valid && !FRAME.ext
      && FRAME.buf_sel != BASIC_BUF && gmask_word == '0
      && (FRAME.rx_word ^ FRAME.stored_word) == 32'h0007_ffff) |=> ACCEPT.hit)
      else $error("standard frame compared unused bits");
   a_ext_all_bits: assert property ((FRAME.valid && FRAME.ext
      && FRAME.buf_sel != BASIC_BUF && gmask_word == '0
      && FRAME.rx_word[0] != FRAME.stored_word[0]) |=> !ACCEPT.hit)
      else $error("extended remote bit not compared");
   a_basic_open: assert property ((FRAME.valid && FRAME.buf_sel == BASIC_BUF
      && bmask_word == EXT_USED_BITS) |=> ACCEPT.hit
      && ACCEPT.merged_word == $past(FRAME.rx_word & used_bits(FRAME.ext)
      | FRAME.stored_word & ~used_bits(FRAME.ext)))
      else $error("basic mask not applied to buffer 14");
   a_read_pending: assert property ((RD && ADDR == IRQ_PENDING_OFS)
      |=> RDATA == $past(st_r.irq_pending))
      else $error("pending read wrong");

   // Filter answer timing and the bits each frame type may touch
   a_valid_follows: assert property (FRAME.valid |=> ACCEPT.valid)
      else $error("filter answer missing");
   a_hit_needs_valid: assert property (!ACCEPT.valid |-> !ACCEPT.hit)
      else $error("hit without a filter request");
   a_exact_match_hits: assert property ((FRAME.valid
      && FRAME.rx_word == FRAME.stored_word) |=> ACCEPT.hit)
      else $error("identical identifier rejected");
   a_std_keeps_low: assert property ((FRAME.valid && !FRAME.ext)
      |=> ACCEPT.merged_word[18:0] == $past(FRAME.stored_word[18:0]))
      else $error("standard frame overwrote unused bits");
   a_ext_global_merge: assert property ((FRAME.valid && FRAME.ext
      && FRAME.buf_sel != BASIC_BUF) |=> ACCEPT.merged_word
      == $past((FRAME.rx_word & gmask_word) | (FRAME.stored_word & ~gmask_word)))
      else $error("global mask merge wrong");
   a_ext_basic_merge: assert property ((FRAME.valid && FRAME.ext
      && FRAME.buf_sel == BASIC_BUF) |=> ACCEPT.merged_word
      == $past((FRAME.rx_word & bmask_word) | (FRAME.stored_word & ~bmask_word)))
      else $error("basic mask merge wrong");
   a_basic_std_low: assert property ((FRAME.valid && !FRAME.ext
      && FRAME.buf_sel == BASIC_BUF) |=> ACCEPT.merged_word[18:0]
      == $past(FRAME.stored_word[18:0]))
      else $error("basic mask touched unused bits");
   // Register port: writes land next cycle, read data idles at zero
   a_enable_lands: assert property ((WR && ADDR == IRQ_ENABLE_OFS)
      |=> st_r.irq_enable == $past(WDATA))
      else $error("enable write lost");
   a_pending_ro: assert property ((WR && ADDR == IRQ_PENDING_OFS && set_vec == '0)
      |=> $stable(st_r.irq_pending))
      else $error("pending register took a write");
   a_rdata_idle: assert property (!RD |=> RDATA == READ_ZERO)
      else $error("read data outside read cycle");
   a_gmask_readback: assert property ((RD && ADDR == GLOBAL_MASK_BASE_OFS)
      |=> RDATA == $past(st_r.gmask_base))
      else $error("mask base read wrong");
   // Request and code against the stored flags
   a_irq_level: assert property (IRQ == |(st_r.irq_pending & st_r.irq_enable))
      else $error("request disagrees with enabled pending");
   a_buf_irq_rises: assert property ((BUF_EVT[0] && st_r.irq_enable[0]
      && !(WR && ADDR == IRQ_ENABLE_OFS)) |=> IRQ)
      else $error("enabled buffer did not raise request");
   a_err_sticky: assert property ((st_r.irq_pending[ERR_BIT]
      && !(WR && ADDR == IRQ_CLEAR_OFS && WDATA[ERR_BIT])) |=> st_r.irq_pending[ERR_BIT])
      else $error("error pending dropped by itself");
   a_code_err_off: assert property ((st_r.irq_pending[ERR_BIT]
      && !st_r.irq_code_enable[ERR_BIT]) |-> INT_CODE != CODE_ERR)
      else $error("suppressed error shown in code");
   a_code_buf0: assert property ((st_r.irq_pending[0] && st_r.irq_code_enable[0]
      && !(st_r.irq_pending[ERR_BIT] && st_r.irq_code_enable[ERR_BIT]))
      |-> INT_CODE == {CODE_REQ, 4'h1})
      else $error("buffer 0 not top in code");

   c_error_code: cover property (INT_CODE == CODE_ERR);
   c_buf14_accept: cover property (FRAME.valid && FRAME.buf_sel == BASIC_BUF ##1 ACCEPT.hit);
   c_set_clear_clash: cover property (WR && ADDR == IRQ_CLEAR_OFS && (WDATA & set_vec) != '0);
   c_std_hit: cover property (FRAME.valid && !FRAME.ext ##1 ACCEPT.hit);
endmodule

// *** verif/cmi_engine_model.sv ***
// Purpose: Protocol engine stand-in that offers frames and transfer/error events
// Assumes: Same SYS_CLK as the block; every request is a one-cycle pulse
// Notes: After each frame pulse the frame fields show inverted data (all zero before the first), so a stale value cannot pass
`timescale 1ns/100ps

module cmi_engine_model (
   input wire logic SYS_CLK,
   output cmi_pkg::cmi_frame_t FRAME,
   output logic [14:0] BUF_EVT,
   output logic ERR_STAT_CHG
);
   import cmi_pkg::*;

   initial begin
      FRAME = '0;
      BUF_EVT = '0;
      ERR_STAT_CHG = 1'b0;
   end

   task automatic frame(input logic ext, input logic [3:0] bsel, input cmi_word_t rx,
                        input cmi_word_t st);
      @(posedge SYS_CLK);
      FRAME <= '{valid: 1'b1, ext: ext, buf_sel: bsel, rx_word: rx, stored_word: st};
      @(posedge SYS_CLK);
      FRAME <= '{valid: 1'b0, ext: ~ext, buf_sel: ~bsel, rx_word: ~rx, stored_word: ~st};
   endtask

   task automatic evt(input logic [14:0] b, input logic e);
      @(posedge SYS_CLK);
      BUF_EVT <= b;
      ERR_STAT_CHG <= e;
      @(posedge SYS_CLK);
      BUF_EVT <= '0;
      ERR_STAT_CHG <= 1'b0;
   endtask
endmodule

// *** verif/cmi_regs_tb.sv ***
// Purpose: Self-checking bench for the acceptance mask and interrupt flag block
// Assumes: Register port strobes last one cycle; read data checked in the cycle after
// Notes: Expected filter and code values are modelled here from the mask and priority rules
`timescale 1ns/100ps

module cmi_regs_tb;
   import cmi_pkg::*;
   logic SYS_CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, ERR_STAT_CHG, IRQ;
   cmi_addr_t ADDR = '0;
   cmi_data_t WDATA = '0, RDATA, pend = '0, en = '0, cen = '0;
   cmi_frame_t FRAME;
   cmi_accept_t ACCEPT;
   cmi_code_t INT_CODE;
   logic [14:0] BUF_EVT;
   int errors = 0, samples_checked = 0, cycles = 0;

   cmi_regs uut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .FRAME(FRAME), .ACCEPT(ACCEPT), .BUF_EVT(BUF_EVT),
      .ERR_STAT_CHG(ERR_STAT_CHG), .IRQ(IRQ), .INT_CODE(INT_CODE));
   cmi_engine_model eng (.SYS_CLK(SYS_CLK), .FRAME(FRAME), .BUF_EVT(BUF_EVT),
      .ERR_STAT_CHG(ERR_STAT_CHG));

   initial begin
      forever #20 SYS_CLK = ~SYS_CLK;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Far beyond the roughly 180 cycles the tests need
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         $display("CHECK FAILED t=%0t timeout", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input cmi_addr_t a, input cmi_data_t d);
      @(posedge SYS_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input cmi_addr_t a, input cmi_data_t e);
      @(posedge SYS_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 chk(RDATA, e, "rdata");
   endtask

   // Error first, then buffer 0 down to buffer 14
   function automatic cmi_code_t exp_code();
      if (pend[15] && cen[15]) return CODE_ERR;
      for (int n = 0; n < 15; n++) if (pend[n] && cen[n]) return {1'b1, 4'(n + 1)};
      return CODE_NONE;
   endfunction

   task automatic chk_int();
      @(posedge SYS_CLK);
      #1 chk(IRQ, |(pend & en), "irq");
      chk(INT_CODE, exp_code(), "code");
      rd(IRQ_PENDING_OFS, pend);
   endtask

   task automatic test_regs();
      cmi_addr_t rw[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
      for (int a = 0; a < 16; a++) rd(a[3:0], REG_RESET);
      foreach (rw[i]) begin
         wr(rw[i], 16'ha5c3 ^ 16'(i));
         rd(rw[i], 16'ha5c3 ^ 16'(i));
      end
      wr(IRQ_PENDING_OFS, 16'hffff);
      rd(IRQ_PENDING_OFS, READ_ZERO);
      wr(IRQ_CLEAR_OFS, 16'hffff);
      rd(IRQ_CLEAR_OFS, READ_ZERO);
      $display("test regs done");
   endtask

   task automatic test_filter();
      cmi_word_t gm = 32'h0030_0006, bm = 32'h8008_0001, st = 32'h1234_5678;
      cmi_word_t d[4] = '{32'h0, 32'h0030_0006, 32'h0000_0004, 32'h8008_0001};
      cmi_word_t m, u, rx;
      logic hit;
      wr(GLOBAL_MASK_BASE_OFS, gm[31:16]);
      wr(GLOBAL_MASK_EXT_OFS, gm[15:0]);
      wr(BUF14_MASK_BASE_OFS, bm[31:16]);
      wr(BUF14_MASK_EXT_OFS, bm[15:0]);
      for (int k = 0; k < 16; k++) begin
         m = k[3] ? bm : gm;
         u = k[2] ? EXT_USED_BITS : STD_USED_BITS;
         rx = st ^ d[k[1:0]];
         hit = ((rx ^ st) & ~m & u) == 32'h0;
         eng.frame(k[2], k[3] ? BASIC_BUF : 4'h3, rx, st);
         #1 chk(ACCEPT.valid, 1'b1, "acc valid");
         chk(ACCEPT.hit, hit, "acc hit");
         if (hit) chk(ACCEPT.merged_word, (st & ~(m & u)) | (rx & m & u), "merged");
      end
      $display("test filter done");
   endtask

   task automatic test_irq();
      en = 16'h8009;
      cen = 16'hffff;
      wr(IRQ_ENABLE_OFS, en);
      wr(IRQ_CODE_ENABLE_OFS, cen);
      eng.evt(15'h0020, 1'b0);
      pend |= 16'h0020;
      chk_int();
      eng.evt(15'h0008, 1'b0);
      pend |= 16'h0008;
      chk_int();
      eng.evt(15'h0000, 1'b1);
      pend |= 16'h8000;
      chk_int();
      cen = 16'h7fff;
      wr(IRQ_CODE_ENABLE_OFS, cen);
      chk_int();
      rd(NODE_STATUS_AND_CODE_OFS, {11'h0, exp_code()});
      cen = 16'h8020;
      wr(IRQ_CODE_ENABLE_OFS, cen);
      chk_int();
      wr(IRQ_CLEAR_OFS, 16'h8000);
      pend &= 16'h7fff;
      chk_int();
      fork
         wr(IRQ_CLEAR_OFS, 16'h0028);
         eng.evt(15'h0008, 1'b0);
      join
      pend &= ~16'h0020;
      chk_int();
      eng.evt(15'h0000, 1'b1);
      pend |= 16'h8000;
      en = 16'h0001;
      wr(IRQ_ENABLE_OFS, en);
      chk_int();
      wr(IRQ_CLEAR_OFS, 16'hffff);
      pend = '0;
      chk_int();
      $display("test irq done");
   endtask

   initial begin
      repeat (20) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      test_regs();
      test_filter();
      test_irq();
      test_done();
   end
endmodule
